// ===== include/tmr_defs.svh
// Register indices, field positions, reset values and timing counts of the timer block.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define TMR_IDX_CTRL      8'h88
`define TMR_IDX_MODE      8'h89
`define TMR_IDX_A_LO      8'h8A
`define TMR_IDX_B_LO      8'h8B
`define TMR_IDX_A_HI      8'h8C
`define TMR_IDX_B_HI      8'h8D
`define TMR_IDX_IRQ_STAT  8'h90
`define TMR_IDX_IRQ_MASK  8'h91

// Fields of timer_control_flags.
`define TMR_CTRL_B_OVF    7
`define TMR_CTRL_B_RUN    6
`define TMR_CTRL_A_OVF    5
`define TMR_CTRL_A_RUN    4
`define TMR_CTRL_B_EDGE   3
`define TMR_CTRL_B_TYPE   2
`define TMR_CTRL_A_EDGE   1
`define TMR_CTRL_A_TYPE   0

// Fields of timer_mode_select.
`define TMR_MODE_A_SEL    1:0
`define TMR_MODE_A_CNT    2
`define TMR_MODE_A_GATE   3
`define TMR_MODE_B_SEL    5:4
`define TMR_MODE_B_CNT    6
`define TMR_MODE_B_GATE   7

// Event bits of status, mask, flag output and acknowledge.
`define TMR_EV_A_OVF      0
`define TMR_EV_B_OVF      1
`define TMR_EV_A_EDGE     2
`define TMR_EV_B_EDGE     3

`define TMR_RST_BYTE      8'h00
`define TMR_RST_EV        4'h0
`define TMR_RST_WORD      32'h0000_0000
`define TMR_MACHINE_CYCLE 12

`endif

// ===== include/tmr_pkg.sv
// Types shared by the timer block.
package tmr_pkg;

    typedef enum logic [1:0] {
        TMR_MODE13,
        TMR_MODE16,
        TMR_RELOAD8,
        TMR_SPLIT
    } tmr_mode_e;

    typedef struct packed {
        logic       ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } tmr_cnt_s;

    typedef struct packed {
        logic cnt_a;
        logic cnt_b;
        logic irq_a;
        logic irq_b;
    } tmr_pins_s;

endpackage

// ===== hdl/tmr_top.sv
// Dual timer/counter with external interrupt flags behind an Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"

module tmr_top
    import tmr_pkg::*;
#(
    parameter int PRESCALE = `TMR_MACHINE_CYCLE
)(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic [9:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    input  wire logic        COUNT_INPUT_A_I,
    input  wire logic        COUNT_INPUT_B_I,
    input  wire logic        EXT_IRQ_A_PIN_I,
    input  wire logic        EXT_IRQ_B_PIN_I,
    input  wire logic [3:0]  IRQ_ACK_I,
    output logic      [3:0]  FLAGS_O,
    output logic             IRQ_O
);

    if (PRESCALE < 2 || PRESCALE > 16)
    begin
        $error("PRESCALE must lie between 2 and 16");
    end

    // Steps one timer; in split arrangement only the low byte, the split high byte stays outside.
    function automatic tmr_cnt_s step(input tmr_mode_e mode, input logic [7:0] lo,
                                      input logic [7:0] hi, input logic inc);
        tmr_cnt_s   r;
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        r   = '{ovf: 1'b0, hi: hi, lo: lo};
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h0_0001;
        c8  = {1'b0, lo} + 9'h001;
        unique case (mode)
            TMR_MODE13:
            begin
                r.lo = {3'b000, lo[4:0]};
                if (inc)
                begin
                    r = '{ovf: c13[13], hi: c13[12:5], lo: {3'b000, c13[4:0]}};
                end
            end
            TMR_MODE16:
            begin
                if (inc)
                begin
                    r = '{ovf: c16[16], hi: c16[15:8], lo: c16[7:0]};
                end
            end
            TMR_RELOAD8:
            begin
                if (inc)
                begin
                    r.ovf = c8[8];
                    r.lo  = c8[8] ? hi : c8[7:0];
                end
            end
            TMR_SPLIT:
            begin
                if (inc)
                begin
                    r.ovf = c8[8];
                    r.lo  = c8[7:0];
                end
            end
        endcase
        return r;
    endfunction

    // Flag update: hardware set beats both software write and acknowledge.
    function automatic logic flag_upd(input logic cur, input logic set, input logic wr,
                                      input logic wval, input logic ack);
        return set | (wr ? wval : (cur & ~ack));
    endfunction

    // Pins come from outside the clock domain; only the second stage is read.
    tmr_pins_s   pin_meta_reg;
    tmr_pins_s   pin_sync_reg;
    logic [3:0]  presc_reg;
    logic [1:0]  samp_cur_reg;
    logic [1:0]  samp_prev_reg;
    logic [1:0]  irq_prev_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  a_lo_reg;
    logic [7:0]  a_hi_reg;
    logic [7:0]  b_lo_reg;
    logic [7:0]  b_hi_reg;
    logic [3:0]  stat_reg;
    logic [3:0]  mask_reg;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic        irq_reg;

    logic        tick;
    logic        req;
    logic        done;
    logic [7:0]  idx;
    logic        wr_lane;
    logic        rd_done;
    tmr_mode_e   mode_a;
    tmr_mode_e   mode_b;
    logic        fall_cnt_a;
    logic        fall_cnt_b;
    logic        fall_irq_a;
    logic        fall_irq_b;
    logic        en_a;
    logic        en_b;
    logic        inc_a;
    logic        inc_b;
    logic        inc_split;
    tmr_cnt_s    nxt_a;
    tmr_cnt_s    nxt_b;
    logic [8:0]  split_hi;
    logic [3:0]  ev_set;
    logic [7:0]  ctrl_next;
    logic [7:0]  rd_mux;

    assign tick = presc_reg == 4'(PRESCALE - 1);
    assign req  = AVS_READ_I | AVS_WRITE_I;
    // The request completes in the cycle where waitrequest stands low.
    assign done    = req & ~wait_reg;
    assign idx     = AVS_ADDRESS_I[9:2];
    assign wr_lane = done & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
    assign rd_done = done & AVS_READ_I;
    assign mode_a  = tmr_mode_e'(mode_reg[`TMR_MODE_A_SEL]);
    assign mode_b  = tmr_mode_e'(mode_reg[`TMR_MODE_B_SEL]);

    // Pin edges on counter inputs are judged from two machine-cycle samples.
    assign fall_cnt_a = tick & samp_prev_reg[0] & ~samp_cur_reg[0];
    assign fall_cnt_b = tick & samp_prev_reg[1] & ~samp_cur_reg[1];
    assign fall_irq_a = irq_prev_reg[0] & ~pin_sync_reg.irq_a;
    assign fall_irq_b = irq_prev_reg[1] & ~pin_sync_reg.irq_b;

    assign en_a = ctrl_reg[`TMR_CTRL_A_RUN]
                & (~mode_reg[`TMR_MODE_A_GATE] | pin_sync_reg.irq_a);
    assign en_b = ctrl_reg[`TMR_CTRL_B_RUN]
                & (~mode_reg[`TMR_MODE_B_GATE] | pin_sync_reg.irq_b);
    assign inc_a = en_a & (mode_reg[`TMR_MODE_A_CNT] ? fall_cnt_a : tick);
    assign inc_b = en_b & (mode_b != TMR_SPLIT)
                 & (mode_reg[`TMR_MODE_B_CNT] ? fall_cnt_b : tick);
    assign inc_split = (mode_a == TMR_SPLIT) & tick & ctrl_reg[`TMR_CTRL_B_RUN];

    always_comb
    begin
        nxt_a    = step(mode_a, a_lo_reg, a_hi_reg, inc_a);
        nxt_b    = step(mode_b, b_lo_reg, b_hi_reg, inc_b);
        split_hi = {1'b0, a_hi_reg} + 9'(inc_split);
        ev_set   = 4'h0;
        ev_set[`TMR_EV_A_OVF]  = nxt_a.ovf;
        // While timer A is split, timer B still runs but no longer owns its flag.
        ev_set[`TMR_EV_B_OVF]  = (mode_a == TMR_SPLIT) ? split_hi[8] : nxt_b.ovf;
        ev_set[`TMR_EV_A_EDGE] = ctrl_reg[`TMR_CTRL_A_TYPE] ? fall_irq_a
                                                            : ~pin_sync_reg.irq_a;
        ev_set[`TMR_EV_B_EDGE] = ctrl_reg[`TMR_CTRL_B_TYPE] ? fall_irq_b
                                                            : ~pin_sync_reg.irq_b;
    end

    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_lane && idx == `TMR_IDX_CTRL)
        begin
            ctrl_next = AVS_WRITEDATA_I[7:0];
        end
        ctrl_next[`TMR_CTRL_A_OVF] = flag_upd(ctrl_reg[`TMR_CTRL_A_OVF], ev_set[`TMR_EV_A_OVF],
            wr_lane && idx == `TMR_IDX_CTRL, AVS_WRITEDATA_I[`TMR_CTRL_A_OVF],
            IRQ_ACK_I[`TMR_EV_A_OVF]);
        ctrl_next[`TMR_CTRL_B_OVF] = flag_upd(ctrl_reg[`TMR_CTRL_B_OVF], ev_set[`TMR_EV_B_OVF],
            wr_lane && idx == `TMR_IDX_CTRL, AVS_WRITEDATA_I[`TMR_CTRL_B_OVF],
            IRQ_ACK_I[`TMR_EV_B_OVF]);
        ctrl_next[`TMR_CTRL_A_EDGE] = flag_upd(ctrl_reg[`TMR_CTRL_A_EDGE],
            ev_set[`TMR_EV_A_EDGE], 1'b0, 1'b0, IRQ_ACK_I[`TMR_EV_A_EDGE]);
        ctrl_next[`TMR_CTRL_B_EDGE] = flag_upd(ctrl_reg[`TMR_CTRL_B_EDGE],
            ev_set[`TMR_EV_B_EDGE], 1'b0, 1'b0, IRQ_ACK_I[`TMR_EV_B_EDGE]);
    end

    always_comb
    begin
        unique case (idx)
            `TMR_IDX_CTRL:     rd_mux = ctrl_reg;
            `TMR_IDX_MODE:     rd_mux = mode_reg;
            `TMR_IDX_A_LO:     rd_mux = a_lo_reg;
            `TMR_IDX_B_LO:     rd_mux = b_lo_reg;
            `TMR_IDX_A_HI:     rd_mux = a_hi_reg;
            `TMR_IDX_B_HI:     rd_mux = b_hi_reg;
            `TMR_IDX_IRQ_STAT: rd_mux = {4'h0, stat_reg};
            `TMR_IDX_IRQ_MASK: rd_mux = {4'h0, mask_reg};
            default:           rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            // Pins idle high, so reset to that level to avoid a false event after release.
            pin_meta_reg  <= '1;
            pin_sync_reg  <= '1;
            irq_prev_reg  <= 2'b11;
            samp_cur_reg  <= 2'b11;
            samp_prev_reg <= 2'b11;
        end
        else
        begin
            pin_meta_reg  <= '{cnt_a: COUNT_INPUT_A_I, cnt_b: COUNT_INPUT_B_I,
                              irq_a: EXT_IRQ_A_PIN_I, irq_b: EXT_IRQ_B_PIN_I};
            pin_sync_reg  <= pin_meta_reg;
            irq_prev_reg  <= {pin_sync_reg.irq_b, pin_sync_reg.irq_a};
            if (tick)
            begin
                samp_cur_reg  <= {pin_sync_reg.cnt_b, pin_sync_reg.cnt_a};
                samp_prev_reg <= samp_cur_reg;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            presc_reg <= 4'h0;
        end
        else
        begin
            presc_reg <= tick ? 4'h0 : presc_reg + 4'h1;
        end
    end

    // A software write to a count byte wins over a count step in the same cycle.
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            a_lo_reg <= `TMR_RST_BYTE;
            a_hi_reg <= `TMR_RST_BYTE;
            b_lo_reg <= `TMR_RST_BYTE;
            b_hi_reg <= `TMR_RST_BYTE;
        end
        else
        begin
            a_lo_reg <= (wr_lane && idx == `TMR_IDX_A_LO) ? AVS_WRITEDATA_I[7:0] : nxt_a.lo;
            b_lo_reg <= (wr_lane && idx == `TMR_IDX_B_LO) ? AVS_WRITEDATA_I[7:0] : nxt_b.lo;
            b_hi_reg <= (wr_lane && idx == `TMR_IDX_B_HI) ? AVS_WRITEDATA_I[7:0] : nxt_b.hi;
            if (wr_lane && idx == `TMR_IDX_A_HI)
            begin
                a_hi_reg <= AVS_WRITEDATA_I[7:0];
            end
            else if (mode_a == TMR_SPLIT)
            begin
                a_hi_reg <= split_hi[7:0];
            end
            else
            begin
                a_hi_reg <= nxt_a.hi;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctrl_reg <= `TMR_RST_BYTE;
            mode_reg <= `TMR_RST_BYTE;
            mask_reg <= `TMR_RST_EV;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            if (wr_lane && idx == `TMR_IDX_MODE)
            begin
                mode_reg <= AVS_WRITEDATA_I[7:0];
            end
            if (wr_lane && idx == `TMR_IDX_IRQ_MASK)
            begin
                mask_reg <= AVS_WRITEDATA_I[3:0];
            end
        end
    end

    // Only bits that the finished read reported are cleared, so a newer event survives.
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            stat_reg <= `TMR_RST_EV;
            irq_reg  <= 1'b0;
        end
        else
        begin
            stat_reg <= ev_set | (stat_reg & ~((rd_done && idx == `TMR_IDX_IRQ_STAT)
                                               ? rdata_reg[3:0] : 4'h0));
            irq_reg  <= |(stat_reg & mask_reg);
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wait_reg  <= 1'b1;
            rdata_reg <= `TMR_RST_WORD;
        end
        else
        begin
            wait_reg <= ~(req & wait_reg);
            if (req && wait_reg)
            begin
                rdata_reg <= {24'h00_0000, rd_mux};
            end
        end
    end

    assign AVS_READDATA_O    = rdata_reg;
    assign AVS_WAITREQUEST_O = wait_reg;
    assign FLAGS_O           = {ctrl_reg[`TMR_CTRL_B_EDGE], ctrl_reg[`TMR_CTRL_A_EDGE],
                                ctrl_reg[`TMR_CTRL_B_OVF], ctrl_reg[`TMR_CTRL_A_OVF]};
    assign IRQ_O             = irq_reg;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);

    a_tick_period: assert property (tick |-> ##12 tick)
        else $error("machine cycle tick not twelve clocks apart");
    a_mode16_step: assert property (mode_a == TMR_MODE16 && en_a && !mode_reg[`TMR_MODE_A_CNT]
        && tick && !done |=> {a_hi_reg, a_lo_reg} == $past({a_hi_reg, a_lo_reg}) + 16'h0001)
        else $error("16-bit timer did not advance by one");
    a_run_freeze: assert property (!ctrl_reg[`TMR_CTRL_A_RUN] && mode_a == TMR_MODE16 && !done
        |=> $stable(a_lo_reg) && $stable(a_hi_reg))
        else $error("stopped timer count changed");
    a_gate_hold: assert property (mode_reg[`TMR_MODE_A_GATE] && !pin_sync_reg.irq_a && !done
        && mode_a == TMR_MODE16 |=> $stable(a_lo_reg))
        else $error("gated timer advanced while its pin was low");
    a_edge_count: assert property (mode_reg[`TMR_MODE_A_CNT] && mode_a == TMR_MODE16 && !fall_cnt_a
        && !done |=> $stable(a_lo_reg))
        else $error("counter advanced without a pin edge");
    a_mode13_roll: assert property (mode_b == TMR_MODE13 && inc_b && b_hi_reg == 8'hFF
        && b_lo_reg[4:0] == 5'h1F && mode_a != TMR_SPLIT && !done
        |=> ctrl_reg[`TMR_CTRL_B_OVF] && b_hi_reg == 8'h00
        && b_lo_reg == 8'h00)
        else $error("13-bit rollover wrong");
    a_reload_hi: assert property (mode_a == TMR_RELOAD8 && inc_a && a_lo_reg == 8'hFF && !done
        |=> a_lo_reg == $past(a_hi_reg) && $stable(a_hi_reg) && ctrl_reg[`TMR_CTRL_A_OVF])
        else $error("auto-reload did not load the high byte");
    a_b_stopped: assert property (mode_b == TMR_SPLIT && !done
        |=> $stable(b_lo_reg) && $stable(b_hi_reg))
        else $error("timer B counted in mode 11");
    a_split_flag: assert property (inc_split && a_hi_reg == 8'hFF && !done
        |=> ctrl_reg[`TMR_CTRL_B_OVF] && a_hi_reg == 8'h00)
        else $error("split high byte overflow did not set timer B flag");
    a_ext_edge: assert property (ctrl_reg[`TMR_CTRL_A_TYPE] && fall_irq_a
        |=> ctrl_reg[`TMR_CTRL_A_EDGE] && FLAGS_O[`TMR_EV_A_EDGE])
        else $error("falling edge did not set the edge flag");
    a_ack_clear: assert property (IRQ_ACK_I[`TMR_EV_A_OVF] && !ev_set[`TMR_EV_A_OVF] && !done
        |=> !ctrl_reg[`TMR_CTRL_A_OVF])
        else $error("acknowledge did not clear the overflow flag");
    a_set_wins: assert property (IRQ_ACK_I[`TMR_EV_A_OVF] && ev_set[`TMR_EV_A_OVF]
        |=> ctrl_reg[`TMR_CTRL_A_OVF])
        else $error("acknowledge beat a same-cycle overflow");
    a_bus_answer: assert property (req && wait_reg |=> !AVS_WAITREQUEST_O)
        else $error("bus request not answered in one cycle");

    c_reload:   cover property (mode_a == TMR_RELOAD8 && nxt_a.ovf);
    c_split:    cover property (inc_split && split_hi[8]);
    c_edge_irq: cover property (fall_irq_b ##[1:4] IRQ_O);
    c_ack:      cover property (IRQ_ACK_I[`TMR_EV_B_OVF] && ev_set[`TMR_EV_B_OVF]);

endmodule
`default_nettype wire

// ===== verification/tmr_pin_model.sv
// Behavioural model of the count and interrupt pins that drive the timer block.
`timescale 1ns/1ps
`default_nettype none

module tmr_pin_model
    import tmr_pkg::*;
#(
    parameter int HOLD_CLKS = 24
)(
    input  wire logic     clk_i,
    output var tmr_pins_s pins_o
);
    // Pins idle high as if pulled up, so an idle pin never looks like a falling edge.
    initial pins_o = '1;

    task automatic drive_cnt(input int which, input logic lvl);
        if (which == 0)
            pins_o.cnt_a <= lvl;
        else
            pins_o.cnt_b <= lvl;
    endtask

    // Each level is held two machine cycles, twice the minimum, so that no edge is missed.
    task automatic count_pulses(input int which, input int n);
        repeat (n)
        begin
            drive_cnt(which, 1'b0);
            repeat (HOLD_CLKS) @(posedge clk_i);
            drive_cnt(which, 1'b1);
            repeat (HOLD_CLKS) @(posedge clk_i);
        end
    endtask

    task automatic set_irq(input int which, input logic lvl);
        if (which == 0)
            pins_o.irq_a <= lvl;
        else
            pins_o.irq_b <= lvl;
        @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// ===== verification/tmr_top_tb.sv
// Self-checking testbench of the dual timer/counter block.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"

module tmr_top_tb
    import tmr_pkg::*;
();
    localparam int MC = 12;
    localparam logic [7:0] REG_LIST [8] = '{`TMR_IDX_CTRL, `TMR_IDX_MODE, `TMR_IDX_A_LO,
        `TMR_IDX_B_LO, `TMR_IDX_A_HI, `TMR_IDX_B_HI, `TMR_IDX_IRQ_STAT, `TMR_IDX_IRQ_MASK};
    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic [9:0]  addr        = 10'h000;
    logic        rd          = 1'b0;
    logic        wr          = 1'b0;
    logic [31:0] wdata       = 32'h0000_0000;
    logic [3:0]  be          = 4'hF;
    logic [3:0]  ack         = 4'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic [3:0]  flags;
    logic        irq;
    tmr_pins_s   pins;
    logic [7:0]  lo_idx;
    logic [7:0]  hi_idx;
    int          failures    = 0;
    int          comparisons = 0;

    always #25 clk = ~clk;

    tmr_top #(.PRESCALE(MC)) u_dut (
        .CLK_SYS_I        (clk),
        .RST_N_I          (rst_n),
        .AVS_ADDRESS_I    (addr),
        .AVS_READ_I       (rd),
        .AVS_WRITE_I      (wr),
        .AVS_WRITEDATA_I  (wdata),
        .AVS_BYTEENABLE_I (be),
        .AVS_READDATA_O   (rdata),
        .AVS_WAITREQUEST_O(waitreq),
        .COUNT_INPUT_A_I  (pins.cnt_a),
        .COUNT_INPUT_B_I  (pins.cnt_b),
        .EXT_IRQ_A_PIN_I  (pins.irq_a),
        .EXT_IRQ_B_PIN_I  (pins.irq_b),
        .IRQ_ACK_I        (ack),
        .FLAGS_O          (flags),
        .IRQ_O            (irq)
    );

    tmr_pin_model #(.HOLD_CLKS(2 * MC)) u_pins (
        .clk_i (clk),
        .pins_o(pins)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // The request stands until waitrequest is sampled low; one idle edge follows each access.
    task automatic bus(input logic wr_n_rd, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        addr  <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        wr    <= wr_n_rd;
        rd    <= !wr_n_rd;
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            failures++;
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b1, idx, d, dummy);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic rin(input logic [7:0] idx, input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk_in(q, lo, hi);
    endtask

    task automatic waitcyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_flag(input int b, input int limit);
        int n;
        n = 0;
        while (flags[b] !== 1'b1 && n < limit)
        begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, flags[b]}, 8'h01);
    endtask

    task automatic ack_pulse(input int b);
        ack <= 4'h1 << b;
        @(posedge clk);
        ack <= 4'h0;
        @(posedge clk);
    endtask

    task automatic done_test(input string name);
        $display("test %s finished, failures so far %0d", name, failures);
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // The whole sequence needs well under two thousand cycles; this bound leaves a wide margin.
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rchk(REG_LIST[i], 8'h00);
        wreg(8'h95, 8'hFF);
        rchk(8'h95, 8'h00);
        be <= 4'h0;
        wreg(`TMR_IDX_MODE, 8'hFF);
        be <= 4'hF;
        rchk(`TMR_IDX_MODE, 8'h00);
        done_test("reset_and_access");
        wreg(`TMR_IDX_MODE, 8'h01);
        wreg(`TMR_IDX_CTRL, 8'h10);
        waitcyc(10 * MC);
        wreg(`TMR_IDX_CTRL, 8'h00);
        rin(`TMR_IDX_A_LO, 8'h0A, 8'h0B);
        waitcyc(5 * MC);
        rin(`TMR_IDX_A_LO, 8'h0A, 8'h0B);
        wreg(`TMR_IDX_IRQ_MASK, 8'h01);
        wreg(`TMR_IDX_A_HI, 8'hFF);
        wreg(`TMR_IDX_A_LO, 8'hFE);
        wreg(`TMR_IDX_CTRL, 8'h10);
        wait_flag(0, 4 * MC);
        waitcyc(2);
        chk({7'h00, irq}, 8'h01);
        rchk(`TMR_IDX_CTRL, 8'h30);
        rchk(`TMR_IDX_IRQ_STAT, 8'h01);
        rchk(`TMR_IDX_IRQ_STAT, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wreg(`TMR_IDX_CTRL, 8'h00);
        rchk(`TMR_IDX_CTRL, 8'h00);
        wreg(`TMR_IDX_IRQ_MASK, 8'h00);
        done_test("timer_16bit");
        wreg(`TMR_IDX_MODE, 8'h00);
        for (int t = 0; t < 2; t++)
        begin
            lo_idx = (t == 0) ? `TMR_IDX_A_LO : `TMR_IDX_B_LO;
            hi_idx = (t == 0) ? `TMR_IDX_A_HI : `TMR_IDX_B_HI;
            wreg(lo_idx, 8'hFF);
            rchk(lo_idx, 8'h1F);
            wreg(hi_idx, 8'hFF);
            wreg(lo_idx, 8'h1E);
            wreg(`TMR_IDX_CTRL, (t == 0) ? 8'h10 : 8'h40);
            wait_flag(t, 4 * MC);
            chk({7'h00, irq}, 8'h00);
            ack_pulse(t);
            chk({7'h00, flags[t]}, 8'h00);
            wreg(`TMR_IDX_CTRL, 8'h00);
            rchk(hi_idx, 8'h00);
        end
        done_test("timer_13bit");
        wreg(`TMR_IDX_MODE, 8'h02);
        wreg(`TMR_IDX_A_HI, 8'h80);
        wreg(`TMR_IDX_A_LO, 8'hFE);
        wreg(`TMR_IDX_CTRL, 8'h10);
        wait_flag(0, 4 * MC);
        wreg(`TMR_IDX_CTRL, 8'h00);
        rchk(`TMR_IDX_A_HI, 8'h80);
        rin(`TMR_IDX_A_LO, 8'h80, 8'h81);
        done_test("auto_reload");
        wreg(`TMR_IDX_MODE, 8'h05);
        wreg(`TMR_IDX_A_LO, 8'h00);
        wreg(`TMR_IDX_A_HI, 8'h00);
        wreg(`TMR_IDX_CTRL, 8'h10);
        u_pins.count_pulses(0, 5);
        waitcyc(3 * MC);
        rchk(`TMR_IDX_A_LO, 8'h05);
        wreg(`TMR_IDX_MODE, 8'h0D);
        u_pins.set_irq(0, 1'b0);
        u_pins.count_pulses(0, 3);
        waitcyc(3 * MC);
        rchk(`TMR_IDX_A_LO, 8'h05);
        u_pins.set_irq(0, 1'b1);
        u_pins.count_pulses(0, 2);
        waitcyc(3 * MC);
        rchk(`TMR_IDX_A_LO, 8'h07);
        wreg(`TMR_IDX_CTRL, 8'h00);
        done_test("counter_and_gate");
        chk({7'h00, flags[2]}, 8'h01);
        ack_pulse(2);
        chk({7'h00, flags[2]}, 8'h00);
        wreg(`TMR_IDX_CTRL, 8'h01);
        u_pins.set_irq(0, 1'b0);
        waitcyc(6);
        chk({7'h00, flags[2]}, 8'h01);
        rchk(`TMR_IDX_CTRL, 8'h03);
        ack_pulse(2);
        waitcyc(MC);
        chk({7'h00, flags[2]}, 8'h00);
        u_pins.set_irq(0, 1'b1);
        wreg(`TMR_IDX_IRQ_MASK, 8'h08);
        wreg(`TMR_IDX_CTRL, 8'h04);
        u_pins.set_irq(1, 1'b0);
        waitcyc(6);
        chk({7'h00, flags[3]}, 8'h01);
        chk({7'h00, irq}, 8'h01);
        ack_pulse(3);
        chk({7'h00, flags[3]}, 8'h00);
        u_pins.set_irq(1, 1'b1);
        wreg(`TMR_IDX_IRQ_MASK, 8'h00);
        done_test("ext_irq");
        wreg(`TMR_IDX_MODE, 8'h33);
        wreg(`TMR_IDX_A_LO, 8'h00);
        wreg(`TMR_IDX_A_HI, 8'hFE);
        wreg(`TMR_IDX_B_LO, 8'h55);
        wreg(`TMR_IDX_B_HI, 8'h66);
        wreg(`TMR_IDX_CTRL, 8'h50);
        wait_flag(1, 4 * MC);
        rin(`TMR_IDX_A_LO, 8'h02, 8'h03);
        rchk(`TMR_IDX_B_LO, 8'h55);
        rchk(`TMR_IDX_B_HI, 8'h66);
        wreg(`TMR_IDX_CTRL, 8'h00);
        done_test("split");
        report_and_stop();
    end
endmodule

`default_nettype wire
